// *** logic/sfir_top.sv ***
// supply fault interrupt registers with avalon-mm slave and interrupt pin
// Operation
// - enable field reads 0h off, 2h on
// - write 1h disables, 3h enables a field
// - global enable field in bits 7-6
// - i2c timeout enable bits 5-4, reset on
// - bad string config enable bits 3-2, reset on
// - led fault enable bits 1-0, reset on
// - bits 15-8 reserved, reset zero
// - status bit reads 1 on fault, else 0
// - clear needs status and clear bit both one
// - upper half pairs crc, sync, pump, capacitor
// - lower half pairs overcurrent, core, overvoltage, undervoltage
// - supply flags at 0Eh, reset zero
// - led enable register at 0Ch, reset AAh
`timescale 1ns/10ps
module sfir_top (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire sfir_pkg::sfir_av_req_t av_i,
	output logic [31:0] av_readdata_o,
	output logic av_waitrequest_o,
	input wire logic [sfir_pkg::N_SUPPLY_FAULTS-1:0] supply_fault_i,
	input wire logic [sfir_pkg::N_LED_EVENTS-1:0] led_event_i,
	output logic irq_o
);
	import sfir_pkg::*;

	// ***********************************
	// bus decode
	// ***********************************
	wire logic req = av_i.read || av_i.write;
	wire logic req_load = req && av_waitrequest_o;
	wire logic wr_do = av_i.write && !av_waitrequest_o;
	wire logic sel_led = av_i.address == ADDR_LED_IRQ_ENABLES;
	wire logic sel_sup = av_i.address == ADDR_SUPPLY_FAULT_FLAGS;
	wire logic sel_sts = av_i.address == ADDR_IRQ_STATUS;
	wire logic sel_msk = av_i.address == ADDR_IRQ_MASK;
	wire logic wr_led = wr_do && sel_led && av_i.byteenable[0];
	wire logic wr_sup_lo = wr_do && sel_sup && av_i.byteenable[0];
	wire logic wr_sup_hi = wr_do && sel_sup && av_i.byteenable[1];
	wire logic wr_sts_hi = wr_do && sel_sts && av_i.byteenable[1];
	wire logic wr_msk_lo = wr_do && sel_msk && av_i.byteenable[0];
	wire logic wr_msk_hi = wr_do && sel_msk && av_i.byteenable[1];

	// ***********************************
	// enable fields
	// ***********************************
	logic [N_ENABLE_FIELDS-1:0] en_state;
	logic [15:0] led_read;

	assign led_read[15:8] = 8'h00;
	genvar gj;
	generate
		for (gj = 0; gj < N_ENABLE_FIELDS; gj++) begin : g_en
			sfir_enable_field #(
				.RESET_ON(RST_LED_IRQ_ENABLES[2*gj+1])
			) u_field (
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.write_i(wr_led),
				.data_i(av_i.writedata[2*gj+1:2*gj]),
				.enabled_o(en_state[gj]),
				.read_o(led_read[2*gj+1:2*gj])
			);
		end
	endgenerate

	// ***********************************
	// supply fault flags
	// ***********************************
	logic [N_SUPPLY_FAULTS-1:0] sup_flag;
	logic [15:0] sup_read;

	genvar gk;
	generate
		for (gk = 0; gk < N_SUPPLY_FAULTS; gk++) begin : g_flag
			wire logic lane_wr = (gk >= N_SUPPLY_FAULTS / 2) ? wr_sup_hi : wr_sup_lo;
			sfir_fault_flag u_flag (
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.detect_i(supply_fault_i[gk]),
				.write_i(lane_wr),
				.status_bit_i(av_i.writedata[2*gk+1]),
				.clear_bit_i(av_i.writedata[2*gk]),
				.flag_o(sup_flag[gk])
			);
			assign sup_read[2*gk+1] = sup_flag[gk];
			assign sup_read[2*gk] = 1'b0;
		end
	endgenerate

	// ***********************************
	// interrupt status and mask
	// ***********************************
	logic [N_LED_EVENTS-1:0] led_evt;
	logic [N_IRQ_SRC-1:0] irq_mask;
	wire logic [N_LED_EVENTS-1:0] led_evt_w1c = wr_sts_hi ? av_i.writedata[10:8] : 3'h0;
	wire logic [N_LED_EVENTS-1:0] next_led_evt = led_event_i | (led_evt & ~led_evt_w1c);
	wire logic [N_IRQ_SRC-1:0] irq_status = {led_evt, sup_flag};
	wire logic [N_IRQ_SRC-1:0] indiv_en = {en_state[EN_I2C_TIMEOUT:EN_LED_FAULT], 8'hFF};
	wire logic next_irq = en_state[EN_GLOBAL] && |(irq_status & irq_mask & indiv_en);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			led_evt <= 3'h0;
		end else begin
			led_evt <= next_led_evt;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_mask <= RST_IRQ_MASK;
		end else begin
			if (wr_msk_lo) begin
				irq_mask[7:0] <= av_i.writedata[7:0];
			end
			if (wr_msk_hi) begin
				irq_mask[10:8] <= av_i.writedata[10:8];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= next_irq;
		end
	end

	// ***********************************
	// bus answer
	// ***********************************
	wire logic [31:0] read_mux = sel_led ? {16'h0000, led_read} :
		sel_sup ? {16'h0000, sup_read} :
		sel_sts ? {21'h0, irq_status} :
		sel_msk ? {21'h0, irq_mask} : 32'h00000000;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			av_waitrequest_o <= 1'b1;
		end else begin
			av_waitrequest_o <= !req_load;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			av_readdata_o <= 32'h00000000;
		end else if (req_load && av_i.read) begin
			av_readdata_o <= read_mux;
		end
	end

	// ***********************************
	// assertions
	// ***********************************
	logic seen_clk;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seen_clk <= 1'b0;
		end else begin
			seen_clk <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence led_read_done;
		av_i.read && !av_waitrequest_o && sel_led;
	endsequence

	sequence sup_read_load;
		req_load && av_i.read && sel_sup;
	endsequence

	sequence global_write(logic [1:0] code);
		wr_led && av_i.writedata[7:6] == code;
	endsequence

	sequence pair_clear(int k);
		(k >= 4 ? wr_sup_hi : wr_sup_lo) && av_i.writedata[2*k+1] && av_i.writedata[2*k] && !supply_fault_i[k];
	endsequence

	en_read_code_a: assert property (led_read_done |-> av_readdata_o[1:0] == (en_state[0] ? 2'h2 : 2'h0) && av_readdata_o[7:6] == (en_state[3] ? 2'h2 : 2'h0)) else $error("enable field read code wrong");
	en_write_on_a: assert property (global_write(2'h3) |=> en_state[EN_GLOBAL] ##1 !global_write(2'h1) [*1] |-> en_state[EN_GLOBAL]) else $error("enable write 3h not taken");
	en_write_off_a: assert property (global_write(2'h1) |=> !en_state[EN_GLOBAL] ##1 !irq_o) else $error("enable write 1h not taken");
	en_hold_a: assert property ((wr_led && av_i.writedata[5:4] inside {2'h0, 2'h2}) |=> $stable(en_state[EN_I2C_TIMEOUT])) else $error("enable changed by 0h or 2h write");
	reset_values_a: assert property (!seen_clk |-> en_state == 4'hF && led_read == RST_LED_IRQ_ENABLES && sup_flag == 8'h00) else $error("reset values wrong");
	led_reserved_a: assert property (led_read_done |-> av_readdata_o[31:8] == 24'h000000) else $error("reserved bits not zero");
	sup_read_map_a: assert property (sup_read_load |=> av_readdata_o[15:0] == {$past(sup_flag[7]), 1'b0, $past(sup_flag[6]), 1'b0, $past(sup_flag[5]), 1'b0, $past(sup_flag[4]), 1'b0, $past(sup_flag[3]), 1'b0, $past(sup_flag[2]), 1'b0, $past(sup_flag[1]), 1'b0, $past(sup_flag[0]), 1'b0}) else $error("supply flag read map wrong");
	crc_sticky_a: assert property (supply_fault_i[FLAG_CRC] ##1 !pair_clear(FLAG_CRC) [*2] |-> sup_flag[FLAG_CRC]) else $error("crc flag not sticky");
	crc_clear_a: assert property (pair_clear(FLAG_CRC) |=> !sup_flag[FLAG_CRC]) else $error("crc paired clear failed");
	uv_half_clear_a: assert property ((wr_sup_lo && av_i.writedata[1:0] == 2'h2 && sup_flag[FLAG_INPUT_UNDERVOLTAGE]) |=> sup_flag[FLAG_INPUT_UNDERVOLTAGE]) else $error("status-only write cleared flag");
	irq_pin_a: assert property ((sup_flag[FLAG_PUMP] && irq_mask[FLAG_PUMP] && en_state[EN_GLOBAL]) |=> irq_o) else $error("interrupt pin not raised");
	irq_release_a: assert property ((irq_status == 11'h000) |=> !irq_o) else $error("interrupt pin not released");

endmodule : sfir_top

// *** logic/sfir_pkg.sv ***
// shared constants and carrier types for the supply fault interrupt registers
package sfir_pkg;

	// ***********************************
	// register map (index, byte = 4 * index)
	// ***********************************
	localparam logic [7:0] IDX_LED_IRQ_ENABLES = 8'h0C;
	localparam logic [7:0] IDX_SUPPLY_FAULT_FLAGS = 8'h0E;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h14;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h15;
	localparam logic [7:0] ADDR_LED_IRQ_ENABLES = 8'(IDX_LED_IRQ_ENABLES * 4);
	localparam logic [7:0] ADDR_SUPPLY_FAULT_FLAGS = 8'(IDX_SUPPLY_FAULT_FLAGS * 4);
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'(IDX_IRQ_STATUS * 4);
	localparam logic [7:0] ADDR_IRQ_MASK = 8'(IDX_IRQ_MASK * 4);

	// ***********************************
	// field layout and encodings
	// ***********************************
	localparam int N_SUPPLY_FAULTS = 8;
	localparam int N_ENABLE_FIELDS = 4;
	localparam int N_LED_EVENTS = 3;
	localparam int N_IRQ_SRC = 11;
	localparam int EN_GLOBAL = 3;
	localparam int EN_I2C_TIMEOUT = 2;
	localparam int EN_BAD_STRING_CFG = 1;
	localparam int EN_LED_FAULT = 0;
	localparam int FLAG_CRC = 7;
	localparam int FLAG_SYNC_MISSING = 6;
	localparam int FLAG_PUMP = 5;
	localparam int FLAG_PUMP_CAP_MISSING = 4;
	localparam int FLAG_INPUT_OVERCURRENT = 3;
	localparam int FLAG_CORE_SUPPLY_LOW = 2;
	localparam int FLAG_INPUT_OVERVOLTAGE = 1;
	localparam int FLAG_INPUT_UNDERVOLTAGE = 0;
	localparam logic [1:0] EN_READ_OFF = 2'h0;
	localparam logic [1:0] EN_READ_ON = 2'h2;
	localparam logic [1:0] EN_WRITE_OFF = 2'h1;
	localparam logic [1:0] EN_WRITE_ON = 2'h3;

	// ***********************************
	// reset values
	// ***********************************
	localparam logic [15:0] RST_LED_IRQ_ENABLES = 16'h00AA;
	localparam logic [15:0] RST_SUPPLY_FAULT_FLAGS = 16'h0000;
	localparam logic [N_IRQ_SRC-1:0] RST_IRQ_MASK = 11'h7FF;

	// ***********************************
	// bus carrier
	// ***********************************
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} sfir_av_req_t;

endpackage : sfir_pkg

// *** logic/sfir_enable_field.sv ***
// one two-bit interrupt enable field with write 1h off, 3h on
`timescale 1ns/10ps
module sfir_enable_field #(
	parameter logic RESET_ON = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic write_i,
	input wire logic [1:0] data_i,
	output logic enabled_o,
	output logic [1:0] read_o
);
	import sfir_pkg::*;

	wire logic turn_on = write_i && (data_i == EN_WRITE_ON);
	wire logic turn_off = write_i && (data_i == EN_WRITE_OFF);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			enabled_o <= RESET_ON;
		end else if (turn_on) begin
			enabled_o <= 1'b1;
		end else if (turn_off) begin
			enabled_o <= 1'b0;
		end
	end

	assign read_o = enabled_o ? EN_READ_ON : EN_READ_OFF;

endmodule : sfir_enable_field

// *** logic/sfir_fault_flag.sv ***
// one sticky fault flag with paired status and clear bits
`timescale 1ns/10ps
module sfir_fault_flag (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic detect_i,
	input wire logic write_i,
	input wire logic status_bit_i,
	input wire logic clear_bit_i,
	output logic flag_o
);
	import sfir_pkg::*;

	// both bits must be one in the same write
	wire logic clear_hit = write_i && status_bit_i && clear_bit_i;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag_o <= 1'b0;
		end else if (detect_i) begin
			flag_o <= 1'b1;
		end else if (clear_hit) begin
			flag_o <= 1'b0;
		end
	end

endmodule : sfir_fault_flag

// *** bench/sfir_host_model.sv ***
// avalon-mm host model for the fault register slave
`timescale 1ns/10ps
module sfir_host_model (
	input wire logic clk_i,
	input wire logic [31:0] readdata_i,
	input wire logic waitrequest_i,
	output sfir_pkg::sfir_av_req_t av_o
);
	import sfir_pkg::*;
	initial begin
		av_o = '0;
	end
	// held until waitrequest is sampled low, one idle edge after
	task xfer(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
		av_o <= '{read: !wr, write: wr, address: a, writedata: {16'h0000, d}, byteenable: 4'h3};
		do @(posedge clk_i); while (waitrequest_i !== 1'b0);
		q = readdata_i;
		av_o <= '0;
		@(posedge clk_i);
	endtask : xfer
endmodule : sfir_host_model

// *** bench/tb.sv ***
// self-checking bench for the supply fault interrupt registers
`timescale 1ns/10ps
module tb;
	import sfir_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] supply_fault_i = 8'h00;
	logic [2:0] led_event_i = 3'h0;
	logic [31:0] av_readdata_o;
	logic av_waitrequest_o;
	logic irq_o;
	sfir_av_req_t av_i;
	int fails = 0;
	int comparisons = 0;
	logic [3:0] en = 4'hF;
	logic [15:0] corner [5] = '{16'h0055, 16'hFFAA, 16'h0000, 16'h00FF, 16'h009C};

	sfir_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .av_i(av_i), .av_readdata_o(av_readdata_o),
		.av_waitrequest_o(av_waitrequest_o), .supply_fault_i(supply_fault_i), .led_event_i(led_event_i),
		.irq_o(irq_o));
	sfir_host_model i_host (.clk_i(clk_i), .readdata_i(av_readdata_o), .waitrequest_i(av_waitrequest_o),
		.av_o(av_i));

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	// ***********************************
	// checks and expectations
	// ***********************************
	task stop_test;
		if (fails == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test
	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task chk_irq(input logic exp);
		repeat (2) @(posedge clk_i);
		comparisons++;
		if (irq_o !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, irq_o, exp);
		end
	endtask : chk_irq
	function automatic logic [31:0] exp_led(input logic [3:0] e);
		exp_led = 32'h0;
		for (int f = 0; f < N_ENABLE_FIELDS; f++) begin
			exp_led[2*f+1] = e[f];
		end
	endfunction : exp_led
	function automatic logic [31:0] exp_flags(input logic [7:0] m);
		exp_flags = 32'h0;
		for (int b = 0; b < N_SUPPLY_FAULTS; b++) begin
			exp_flags[2*b+1] = m[b];
		end
	endfunction : exp_flags
	task rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		i_host.xfer(1'b0, a, 16'h0000, q);
		chk_reg(q, exp);
	endtask : rd
	task wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		i_host.xfer(1'b1, a, d, q);
	endtask : wr
	task wr_en(input logic [15:0] d);
		for (int f = 0; f < N_ENABLE_FIELDS; f++) begin
			if (d[2*f+:2] == 2'h1) en[f] = 1'b0;
			else if (d[2*f+:2] == 2'h3) en[f] = 1'b1;
		end
		wr(ADDR_LED_IRQ_ENABLES, d);
	endtask : wr_en
	task pulse(input logic [7:0] s, input logic [2:0] l);
		supply_fault_i <= s;
		led_event_i <= l;
		@(posedge clk_i);
		supply_fault_i <= 8'h00;
		led_event_i <= 3'h0;
		repeat (3) @(posedge clk_i);
	endtask : pulse

	// ***********************************
	// main sequence
	// ***********************************
	initial begin
		logic [7:0] m;
		int j;
		void'($urandom(62112));
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		rd(ADDR_LED_IRQ_ENABLES, 32'h0000_00AA);
		rd(ADDR_SUPPLY_FAULT_FLAGS, 32'h0);
		rd(ADDR_IRQ_MASK, 32'h7FF);
		chk_irq(1'b0);
		wr(8'h04, 16'hFFFF);
		rd(8'h04, 32'h0);
		for (int i = 0; i < 24; i++) begin
			wr_en(i < 5 ? corner[i] : 16'($urandom));
			rd(ADDR_LED_IRQ_ENABLES, exp_led(en));
		end
		wr_en(16'h00FF);
		for (int k = 0; k < N_SUPPLY_FAULTS; k++) begin
			j = (k + 1 + $urandom_range(6)) % N_SUPPLY_FAULTS;
			m = 8'(1 << k) | 8'(1 << j);
			pulse(m, 3'h0);
			chk_irq(1'b1);
			rd(ADDR_SUPPLY_FAULT_FLAGS, exp_flags(m));
			wr(ADDR_SUPPLY_FAULT_FLAGS, 16'(1 << (2*k+1)));
			wr(ADDR_SUPPLY_FAULT_FLAGS, 16'(1 << (2*k)));
			rd(ADDR_SUPPLY_FAULT_FLAGS, exp_flags(m));
			wr(ADDR_SUPPLY_FAULT_FLAGS, 16'(3 << (2*k)));
			rd(ADDR_SUPPLY_FAULT_FLAGS, exp_flags(m & ~8'(1 << k)));
			wr(ADDR_SUPPLY_FAULT_FLAGS, 16'(3 << (2*j)));
			chk_irq(1'b0);
		end
		wr_en(16'h0040);
		pulse(8'h01, 3'h0);
		chk_irq(1'b0);
		wr_en(16'h00C0);
		chk_irq(1'b1);
		wr(ADDR_SUPPLY_FAULT_FLAGS, 16'h0003);
		chk_irq(1'b0);
		wr_en(16'h0001);
		pulse(8'h00, 3'h1);
		chk_irq(1'b0);
		wr_en(16'h0003);
		chk_irq(1'b1);
		wr(ADDR_IRQ_MASK, 16'h0000);
		chk_irq(1'b0);
		wr(ADDR_IRQ_MASK, 16'h07FF);
		chk_irq(1'b1);
		wr(ADDR_IRQ_STATUS, 16'h0100);
		chk_irq(1'b0);
		rd(ADDR_IRQ_STATUS, 32'h0);
		stop_test;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		stop_test;
	end
endmodule : tb
